// file: rtl/dcl_bank.sv
// channel limit and rate converter configuration register bank
//
// Function
// - record force bit picks custom over standard limit in dynamic mode
// - record mask bits 6..3 enable channels four..one
// - playback force bit picks custom over standard limit in dynamic mode
// - playback mask bits 6..3 enable channels four..one
// - reserved bits 2-0 read zero, write reset
// - converter bit 7 enables the rate converter
// - converter bit 6 set disables auto detection
// - all registers reset to zero
`timescale 1ns/1ps
`include "dcl_map.svh"
module dcl_bank
  import dcl_pkg::*;
(
  // clock and reset
  input  wire logic        mclk_in,
  input  wire logic        reset_in,
  input  wire logic        clk_en_in,
  // register port
  input  wire logic [7:0]  reg_addr_in,
  input  wire dcl_byte_t   reg_wdata_in,
  input  wire logic        reg_write_in,
  input  wire logic        reg_read_in,
  output dcl_byte_t        reg_rdata_out,
  output logic             reg_rvalid_out,
  // path state from the codec core
  input  wire logic        record_dynamic_mode_in,
  input  wire logic        playback_dynamic_mode_in,
  input  wire dcl_chmask_t record_limit_select_in,
  input  wire dcl_chmask_t playback_limit_select_in,
  // configuration out
  output logic [3:0]       record_channel_enable_out,
  output logic [3:0]       playback_channel_enable_out,
  output logic             rate_converter_enable_out,
  output logic             rate_converter_autodetect_off_out,
  output dcl_byte_t        rate_converter_cfg_b_out
);

  // ==========================================================
  // storage
  // configuration registers, one per offset
  dcl_byte_t  record_channel_limit_cfg_r;
  dcl_byte_t  playback_channel_limit_cfg_r;
  dcl_byte_t  rate_converter_cfg_a_r;
  dcl_byte_t  rate_converter_cfg_b_r;
  // read port flops
  dcl_byte_t  reg_rdata_r;
  logic       reg_rvalid_r;
  // channel enable flops, one bit per channel
  logic [3:0] record_enable_r;
  logic [3:0] playback_enable_r;

  // ==========================================================
  // address decode
  wire hit_rec;
  wire hit_play;
  wire hit_rca;
  wire hit_rcb;
  assign hit_rec  = reg_addr_in == `DCL_OFS_REC_LIMIT;
  assign hit_play = reg_addr_in == `DCL_OFS_PLAY_LIMIT;
  assign hit_rca  = reg_addr_in == `DCL_OFS_RC_CFG_A;
  assign hit_rcb  = reg_addr_in == `DCL_OFS_RC_CFG_B;

  // reserved bits masked on write so they always read zero
  wire dcl_byte_t rec_nxt;
  wire dcl_byte_t play_nxt;
  wire dcl_byte_t rca_nxt;
  assign rec_nxt  = reg_wdata_in & `DCL_LIMIT_WMASK;
  assign play_nxt = reg_wdata_in & `DCL_LIMIT_WMASK;
  assign rca_nxt  = reg_wdata_in & `DCL_RC_A_WMASK;

  // unmapped addresses read as zero
  dcl_byte_t rdata_nxt;
  always_comb
  begin
    if (hit_rec)
      rdata_nxt = record_channel_limit_cfg_r;
    else if (hit_play)
      rdata_nxt = playback_channel_limit_cfg_r;
    else if (hit_rca)
      rdata_nxt = rate_converter_cfg_a_r;
    else if (hit_rcb)
      rdata_nxt = rate_converter_cfg_b_r;
    else
      rdata_nxt = `DCL_RESET_VAL;
  end

  // ==========================================================
  // write strobes; offsets differ, so at most one is high
  wire            wr_taken;
  wire            wr_rec;
  wire            wr_play;
  wire            wr_rca;
  wire            wr_rcb;
  wire dcl_byte_t rcb_nxt;

  assign wr_taken = clk_en_in & reg_write_in;
  assign wr_rec   = wr_taken & hit_rec;
  assign wr_play  = wr_taken & hit_play;
  assign wr_rca   = wr_taken & hit_rca;
  assign wr_rcb   = wr_taken & hit_rcb;

  // converter b has no reserved bits
  assign rcb_nxt  = reg_wdata_in & `DCL_RC_B_WMASK;

  // ==========================================================
  // register writes; reset acts even with the enable low
  always_ff @(posedge mclk_in)
  begin
    if (reset_in)
      record_channel_limit_cfg_r <= `DCL_RESET_VAL;
    else if (wr_rec)
      record_channel_limit_cfg_r <= rec_nxt;
  end

  always_ff @(posedge mclk_in)
  begin
    if (reset_in)
      playback_channel_limit_cfg_r <= `DCL_RESET_VAL;
    else if (wr_play)
      playback_channel_limit_cfg_r <= play_nxt;
  end

  always_ff @(posedge mclk_in)
  begin
    if (reset_in)
      rate_converter_cfg_a_r <= `DCL_RESET_VAL;
    else if (wr_rca)
      rate_converter_cfg_a_r <= rca_nxt;
  end

  always_ff @(posedge mclk_in)
  begin
    if (reset_in)
      rate_converter_cfg_b_r <= `DCL_RESET_VAL;
    else if (wr_rcb)
      rate_converter_cfg_b_r <= rcb_nxt;
  end

  // ==========================================================
  // read port, one cycle latency; idle cycles return zero
  // rdata stands until the next enabled edge
  wire dcl_byte_t rdata_sel;
  assign rdata_sel = reg_read_in ? rdata_nxt : `DCL_RESET_VAL;

  always_ff @(posedge mclk_in)
  begin
    if (reset_in)
      reg_rvalid_r <= `DCL_FLAG_RESET;
    else if (clk_en_in)
      reg_rvalid_r <= reg_read_in;
  end

  always_ff @(posedge mclk_in)
  begin
    if (reset_in)
      reg_rdata_r <= `DCL_RESET_VAL;
    else if (clk_en_in)
      reg_rdata_r <= rdata_sel;
  end

  // ==========================================================
  // channel limit selection
  wire [3:0] record_enable_nxt;
  wire [3:0] playback_enable_nxt;

  dcl_chan_sel u_record_sel (
    .dynamic_mode_in    (record_dynamic_mode_in),
    .force_custom_in    (record_channel_limit_cfg_r[`DCL_FORCE_BIT]),
    .custom_mask_in     (record_channel_limit_cfg_r[`DCL_MASK_HI:`DCL_MASK_LO]),
    .standard_mask_in   (record_limit_select_in),
    .channel_enable_out (record_enable_nxt)
  );

  dcl_chan_sel u_playback_sel (
    .dynamic_mode_in    (playback_dynamic_mode_in),
    .force_custom_in    (playback_channel_limit_cfg_r[`DCL_FORCE_BIT]),
    .custom_mask_in     (playback_channel_limit_cfg_r[`DCL_MASK_HI:`DCL_MASK_LO]),
    .standard_mask_in   (playback_limit_select_in),
    .channel_enable_out (playback_enable_nxt)
  );

  // ==========================================================
  // channel enable flops, one per channel and path
  // registered so outputs come straight from flops
  genvar ch;
  generate
    for (ch = 0; ch < 4; ch++)
    begin : g_chan
      always_ff @(posedge mclk_in)
      begin
        if (reset_in)
          record_enable_r[ch] <= `DCL_FLAG_RESET;
        else if (clk_en_in)
          record_enable_r[ch] <= record_enable_nxt[ch];
      end

      always_ff @(posedge mclk_in)
      begin
        if (reset_in)
          playback_enable_r[ch] <= `DCL_FLAG_RESET;
        else if (clk_en_in)
          playback_enable_r[ch] <= playback_enable_nxt[ch];
      end
    end
  endgenerate

  // ==========================================================
  // outputs
  // converter fields come straight from the config flops
  assign reg_rdata_out                     = reg_rdata_r;
  assign reg_rvalid_out                    = reg_rvalid_r;
  assign record_channel_enable_out         = record_enable_r;
  assign playback_channel_enable_out       = playback_enable_r;
  assign rate_converter_enable_out         = rate_converter_cfg_a_r[`DCL_RC_EN_BIT];
  assign rate_converter_autodetect_off_out =
    rate_converter_cfg_a_r[`DCL_RC_AUTO_OFF_BIT];
  assign rate_converter_cfg_b_out          = rate_converter_cfg_b_r;

endmodule

// file: rtl/dcl_chan_sel.sv
// per-path channel enable selection between standard and custom limit
`timescale 1ns/1ps
module dcl_chan_sel
  import dcl_pkg::*;
(
  // mode
  input  wire logic        dynamic_mode_in,
  input  wire logic        force_custom_in,
  // sources
  input  wire dcl_chmask_t custom_mask_in,
  input  wire dcl_chmask_t standard_mask_in,
  // result
  output logic [3:0]       channel_enable_out
);
  wire use_custom;

  // mask only matters in dynamic mode with force set
  assign use_custom = dynamic_mode_in & force_custom_in;

  // mask bit n drives channel n+1
  assign channel_enable_out = use_custom ? custom_mask_in : standard_mask_in;
endmodule

// file: rtl/dcl_map.svh
// register offsets, field positions and reset values of the channel limit bank
`ifndef DCL_MAP_SVH
`define DCL_MAP_SVH

`define DCL_OFS_REC_LIMIT      8'h0E
`define DCL_OFS_PLAY_LIMIT     8'h0F
`define DCL_OFS_RC_CFG_A       8'h17
`define DCL_OFS_RC_CFG_B       8'h18

`define DCL_FORCE_BIT          7
`define DCL_MASK_HI            6
`define DCL_MASK_LO            3
`define DCL_RC_EN_BIT          7
`define DCL_RC_AUTO_OFF_BIT    6

`define DCL_LIMIT_WMASK        8'hF8
`define DCL_RC_A_WMASK         8'hC0
`define DCL_RC_B_WMASK         8'hFF

`define DCL_RESET_VAL          8'h00
`define DCL_FLAG_RESET         1'b0

`endif

// file: rtl/dcl_pkg.sv
// types shared by the channel limit bank
package dcl_pkg;
  typedef logic [7:0] dcl_byte_t;
  typedef logic [3:0] dcl_chmask_t;
endpackage

// file: tb/dcl_bank_properties.sv
// port assertions for the channel limit bank
`timescale 1ns/1ps
module dcl_bank_chk
  import dcl_pkg::*;
(
  input wire logic        mclk_in,
  input wire logic        reset_in,
  input wire logic        clk_en_in,
  input wire logic [7:0]  reg_addr_in,
  input wire dcl_byte_t   reg_wdata_in,
  input wire logic        reg_write_in,
  input wire logic        reg_read_in,
  input wire dcl_byte_t   reg_rdata_out,
  input wire logic        reg_rvalid_out,
  input wire logic        record_dynamic_mode_in,
  input wire logic        playback_dynamic_mode_in,
  input wire dcl_chmask_t record_limit_select_in,
  input wire dcl_chmask_t playback_limit_select_in,
  input wire logic [3:0]  record_channel_enable_out,
  input wire logic [3:0]  playback_channel_enable_out,
  input wire logic        rate_converter_enable_out,
  input wire logic        rate_converter_autodetect_off_out
);
  // ==========
  // mask history, enables land two edges after a write
  logic [3:0] msk_d1;
  logic [3:0] msk_d2;
  always_ff @(posedge mclk_in)
  begin
    msk_d1 <= reg_wdata_in[6:3];
    msk_d2 <= msk_d1;
  end
  default clocking @(posedge mclk_in); endclocking
  default disable iff (reset_in);
  rec_std_a: assert property (!reset_in && clk_en_in && !record_dynamic_mode_in
    |=> record_channel_enable_out == $past(record_limit_select_in)) else $error("record std");
  play_std_a: assert property (!reset_in && clk_en_in && !playback_dynamic_mode_in
    |=> playback_channel_enable_out == $past(playback_limit_select_in)) else $error("play std");
  rec_cust_a: assert property (clk_en_in && reg_write_in
    && reg_addr_in == 8'h0E && reg_wdata_in[7] ##1 clk_en_in && record_dynamic_mode_in
    |=> record_channel_enable_out == msk_d2) else $error("record custom");
  play_cust_a: assert property (clk_en_in && reg_write_in
    && reg_addr_in == 8'h0F && reg_wdata_in[7] ##1 clk_en_in && playback_dynamic_mode_in
    |=> playback_channel_enable_out == msk_d2) else $error("play custom");
  rsvd_read_a: assert property (clk_en_in && reg_read_in && reg_addr_in[7:1] == 7'h07
    |=> reg_rdata_out[2:0] == 3'h0) else $error("reserved bits");
  rc_write_a: assert property (clk_en_in && reg_write_in
    && reg_addr_in == 8'h17
    |=> {rate_converter_enable_out, rate_converter_autodetect_off_out}
    == $past(reg_wdata_in[7:6])) else $error("converter write");
  rc_read_a: assert property (clk_en_in && reg_read_in && reg_addr_in == 8'h17
    |=> reg_rdata_out == {$past(rate_converter_enable_out),
    $past(rate_converter_autodetect_off_out), 6'h00}) else $error("converter read");
  reset_zero_a: assert property (disable iff (1'b0) reset_in |=> !reg_rvalid_out
    && record_channel_enable_out == 4'h0 && !rate_converter_enable_out) else $error("reset");
endmodule
bind dcl_bank dcl_bank_chk i_chk (.*);

// file: tb/dcl_bank_tb.sv
// self-checking bench for the channel limit bank
`timescale 1ns/1ps
module dcl_bank_tb
  import dcl_pkg::*;
;
  logic        mclk_in = 1'b0;
  logic        reset_in = 1'b1;
  logic        clk_en_in = 1'b1;
  logic [7:0]  reg_addr_in = 8'h00;
  dcl_byte_t   reg_wdata_in = 8'h00;
  logic        reg_write_in = 1'b0;
  logic        reg_read_in = 1'b0;
  logic        record_dynamic_mode_in = 1'b0;
  logic        playback_dynamic_mode_in = 1'b0;
  dcl_chmask_t record_limit_select_in = 4'h3;
  dcl_chmask_t playback_limit_select_in = 4'h5;
  dcl_byte_t   reg_rdata_out;
  logic        reg_rvalid_out;
  logic [3:0]  record_channel_enable_out;
  logic [3:0]  playback_channel_enable_out;
  logic        rate_converter_enable_out;
  logic        rate_converter_autodetect_off_out;
  dcl_byte_t   rate_converter_cfg_b_out;
  logic [7:0]  ofs [4] = '{8'h0E, 8'h0F, 8'h17, 8'h18};
  int          n_fail = 0;
  int          checked = 0;
  logic [7:0]  rc_bits;
  dcl_bank i_dut (.*);
  assign rc_bits = {6'h00, rate_converter_enable_out, rate_converter_autodetect_off_out};
  initial forever #12.5 mclk_in = ~mclk_in;
  // ==========
  // access tasks
  task automatic chk(string n, logic [7:0] s, logic [7:0] e);
    checked++;
    if (s !== e)
    begin
      n_fail++;
      $display("CHECK FAILED %s exp %h saw %h", n, e, s);
    end
  endtask
  // waits out the extra edge the channel enables need
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge mclk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_write_in <= 1'b1;
    @(posedge mclk_in);
    reg_write_in <= 1'b0;
    repeat (2) @(negedge mclk_in);
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] e);
    @(posedge mclk_in);
    reg_addr_in <= a;
    reg_read_in <= 1'b1;
    @(posedge mclk_in);
    reg_read_in <= 1'b0;
    @(negedge mclk_in);
    chk("rvalid", {7'h00, reg_rvalid_out}, 8'h01);
    chk("rdata", reg_rdata_out, e);
    @(negedge mclk_in);
    chk("rvalid", {7'h00, reg_rvalid_out}, 8'h00);
  endtask
  task automatic mode(logic r, logic p);
    @(posedge mclk_in);
    record_dynamic_mode_in <= r;
    playback_dynamic_mode_in <= p;
    repeat (2) @(negedge mclk_in);
  endtask
  task automatic tally_and_finish;
    if (n_fail == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // ==========
  // tests
  initial
  begin
    repeat (4) @(posedge mclk_in);
    reset_in <= 1'b0;
    foreach (ofs[i]) rd(ofs[i], 8'h00);
    // reserved bits are only ever written with their reset value
    wr(8'h0E, 8'hF8);
    rd(8'h0E, 8'hF8);
    wr(8'h0F, 8'hC0);
    rd(8'h0F, 8'hC0);
    chk("rec", 8'(record_channel_enable_out), 8'h03);
    chk("play", 8'(playback_channel_enable_out), 8'h05);
    mode(1'b1, 1'b1);
    chk("rec", 8'(record_channel_enable_out), 8'h0F);
    chk("play", 8'(playback_channel_enable_out), 8'h08);
    wr(8'h0E, 8'h88);
    chk("rec", 8'(record_channel_enable_out), 8'h01);
    wr(8'h0E, 8'h08);
    chk("rec", 8'(record_channel_enable_out), 8'h03);
    wr(8'h0F, 8'h40);
    chk("play", 8'(playback_channel_enable_out), 8'h05);
    wr(8'h0F, 8'hB8);
    chk("play", 8'(playback_channel_enable_out), 8'h07);
    mode(1'b0, 1'b0);
    chk("play", 8'(playback_channel_enable_out), 8'h05);
    wr(8'h0E, 8'hF8);
    chk("rec", 8'(record_channel_enable_out), 8'h03);
    wr(8'h17, 8'hC0);
    rd(8'h17, 8'hC0);
    chk("rc", rc_bits, 8'h03);
    wr(8'h17, 8'h40);
    chk("rc", rc_bits, 8'h01);
    wr(8'h18, 8'hA5);
    rd(8'h18, 8'hA5);
    chk("cfg_b", rate_converter_cfg_b_out, 8'hA5);
    rd(8'h10, 8'h00);
    // ==========
    // frozen clock enable, then reset in mid-run
    @(posedge mclk_in);
    clk_en_in <= 1'b0;
    wr(8'h18, 8'h00);
    chk("cfg_b", rate_converter_cfg_b_out, 8'hA5);
    @(posedge mclk_in);
    clk_en_in <= 1'b1;
    @(posedge mclk_in);
    reset_in <= 1'b1;
    @(posedge mclk_in);
    reset_in <= 1'b0;
    @(negedge mclk_in);
    chk("cfg_b", rate_converter_cfg_b_out, 8'h00);
    chk("rc", rc_bits, 8'h00);
    chk("rec", 8'(record_channel_enable_out), 8'h00);
    tally_and_finish;
  end
  // about 70 cycles of tests, seven times that is a hang
  initial
  begin
    repeat (500) @(posedge mclk_in);
    n_fail++;
    tally_and_finish;
  end
endmodule
